// File: hw/clk_synth_pkg.sv
// Shared constants for the clock synthesizer control logic
`default_nettype none
package clk_synth_pkg;
    localparam logic [7:0] SLAVE_ADDR_W = 8'hD2;
    localparam logic [6:0] SLAVE_ADDR7 = 7'h69;
    localparam int CMD_TYPE_BIT = 7;
    localparam int NUM_CTRL_BYTES = 8;
    localparam logic [7:0] BLOCK_COUNT = 8'h08;
    localparam int FSEL_WIDTH = 5;
    localparam logic [4:0] FSEL_SAFE = 5'h1C;
    localparam int BYTE0_FSEL_LSB = 0;
    localparam int BYTE0_DRV_BIT = 6;
    // Power-up defaults of the control bytes; byte 0 low bits hold the latched code
    localparam logic [7:0] BYTE0_RST = 8'h40;
    localparam logic [7:0] BYTE1_RST = 8'h7F;
    localparam logic [7:0] BYTEX_RST = 8'hFF;
    localparam logic [7:0] WRITE_MASK0 = 8'h40;
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
endpackage : clk_synth_pkg
`default_nettype wire

// File: hw/serial_pins_if.sv
// Synchronised serial pin samples with decoded bus conditions
`default_nettype none
interface serial_pins_if;
    logic sclRise;
    logic sclFall;
    logic sdaIn;
    logic startSeen;
    logic stopSeen;
    modport producer(output sclRise, output sclFall, output sdaIn, output startSeen,
        output stopSeen);
    modport consumer(input sclRise, input sclFall, input sdaIn, input startSeen,
        input stopSeen);
endinterface : serial_pins_if
`default_nettype wire

// File: hw/serial_pin_sync.sv
// Two-stage synchronisers and edge, start and stop detection for the serial pins
`default_nettype none
module serial_pin_sync (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sclPin,
    input wire logic sdaPin,
    serial_pins_if.producer pins
);
    logic [1:0] sclMeta_q;
    logic [1:0] sdaMeta_q;
    logic sclOld_q;
    logic sdaOld_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sclMeta_q <= 2'h3;
            sdaMeta_q <= 2'h3;
            sclOld_q <= 1'b1;
            sdaOld_q <= 1'b1;
        end else begin
            sclMeta_q <= {sclMeta_q[0], sclPin};
            sdaMeta_q <= {sdaMeta_q[0], sdaPin};
            sclOld_q <= sclMeta_q[1];
            sdaOld_q <= sdaMeta_q[1];
        end
    end

    assign pins.sclRise = sclMeta_q[1] & ~sclOld_q;
    assign pins.sclFall = ~sclMeta_q[1] & sclOld_q;
    assign pins.sdaIn = sdaMeta_q[1];
    assign pins.startSeen = sclMeta_q[1] & sclOld_q & sdaOld_q & ~sdaMeta_q[1];
    assign pins.stopSeen = sclMeta_q[1] & sclOld_q & ~sdaOld_q & sdaMeta_q[1];
endmodule // serial_pin_sync
`default_nettype wire

// File: hw/fsel_latch.sv
// One-shot capture of the frequency-select straps on the power-good strobe
`default_nettype none
module fsel_latch (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cpu_power_good_n,
    input wire logic [4:0] freqSelPins,
    output logic [4:0] latchedSel,
    output logic latchDone
);
    logic [1:0] pgMeta_q;
    logic [9:0] fsMeta_q;
    logic done_q;
    logic [4:0] sel_q;
    logic take;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pgMeta_q <= 2'h3;
            fsMeta_q <= 10'h000;
        end else begin
            pgMeta_q <= {pgMeta_q[0], cpu_power_good_n};
            fsMeta_q <= {fsMeta_q[4:0], freqSelPins};
        end
    end

    assign take = ~pgMeta_q[1] & ~done_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            sel_q <= clk_synth_pkg::FSEL_SAFE;
        end else if (take) begin
            done_q <= 1'b1;
            sel_q <= fsMeta_q[9:5];
        end
    end

    assign latchedSel = sel_q;
    assign latchDone = done_q;

    a_sel_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(done_q) |-> $stable(sel_q)) else $error("select code changed after latch");
    a_capture_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        !done_q ##1 done_q |-> $past(!pgMeta_q[1])) else $error("latched without low strobe");
endmodule // fsel_latch
`default_nettype wire

// File: hw/clock_synth_select_and_smbus.sv
// Top of the clock synthesizer control: select latch and serial control-byte slave
`default_nettype none
module clock_synth_select_and_smbus #(
    parameter int NUM_BYTES = clk_synth_pkg::NUM_CTRL_BYTES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cpu_power_good_n,
    input wire logic freq_select_bit0,
    input wire logic freq_select_bit1,
    input wire logic freq_select_bit2,
    input wire logic freq_select_bit3,
    input wire logic freq_select_bit4,
    input wire logic powerDown,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic [4:0] freqCode,
    output logic freqCodeValid,
    output logic [8*NUM_BYTES-1:0] ctrlBytes
);
    // Index field is seven bits wide, so at most 127 bytes are reachable
    if (NUM_BYTES < 2 || NUM_BYTES > 127) begin : g_bad_size
        $error("NUM_BYTES out of range");
    end

    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WDATA, ST_WACK,
        ST_RDATA, ST_RACK
    } slave_state_e;

    // ------------------------------------------------------------
    // Select latch
    // ------------------------------------------------------------
    logic [4:0] latchedSel;
    logic latchDone;

    fsel_latch u_latch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cpu_power_good_n(cpu_power_good_n),
        .freqSelPins({freq_select_bit4, freq_select_bit3, freq_select_bit2,
            freq_select_bit1, freq_select_bit0}),
        .latchedSel(latchedSel),
        .latchDone(latchDone)
    );

    function automatic logic reservedCode(input logic [4:0] c);
        return (c[4:2] == 3'b001) || (c[4:1] == 4'b0111) || (c[4:1] == 4'b1000)
            || (c == 5'b11011) || (c == 5'b11111);
    endfunction

    logic [4:0] codeSafe;
    assign codeSafe = reservedCode(latchedSel) ? clk_synth_pkg::FSEL_SAFE : latchedSel;

    logic [4:0] freqCode_q;
    logic freqCodeValid_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            freqCode_q <= clk_synth_pkg::FSEL_SAFE;
            freqCodeValid_q <= 1'b0;
        end else begin
            freqCode_q <= codeSafe;
            freqCodeValid_q <= latchDone;
        end
    end
    assign freqCode = freqCode_q;
    assign freqCodeValid = freqCodeValid_q;

    // ------------------------------------------------------------
    // Serial pin front end
    // ------------------------------------------------------------
    serial_pins_if pins ();

    serial_pin_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sclPin(sclIn),
        .sdaPin(sdaIn),
        .pins(pins)
    );

    // ------------------------------------------------------------
    // Control byte storage
    // ------------------------------------------------------------
    logic [7:0] regs_q [NUM_BYTES];
    logic wrEn;
    logic [6:0] wrIdx;
    logic [7:0] wrData;

    for (genvar i = 0; i < NUM_BYTES; i++) begin : g_reg
        localparam logic [7:0] RST = (i == 0) ? clk_synth_pkg::BYTE0_RST :
            (i == 1) ? clk_synth_pkg::BYTE1_RST : clk_synth_pkg::BYTEX_RST;
        localparam logic [7:0] MASK = (i == 0) ? clk_synth_pkg::WRITE_MASK0 : 8'hFF;
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                regs_q[i] <= RST;
            end else if (wrEn && wrIdx == 7'(i)) begin
                regs_q[i] <= (regs_q[i] & ~MASK) | (wrData & MASK);
            end
        end
        // byte 0 low bits mirror the latched selects
        assign ctrlBytes[8*i +: 8] = (i == 0) ? {regs_q[i][7:5], latchedSel} : regs_q[i];
    end

    function automatic logic [7:0] readByte(input logic [6:0] idx, input logic [4:0] sel,
        input logic [7:0] b0, input logic [7:0] bx);
        if (idx == 7'h00) begin
            return {b0[7:5], sel};
        end
        return bx;
    endfunction

    // ------------------------------------------------------------
    // Slave state machine
    // ------------------------------------------------------------
    slave_state_e state_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic readMode_q;
    logic blockMode_q;
    logic countPhase_q;
    logic [6:0] index_q;
    logic [7:0] txByte_q;
    logic ackDrive_q;
    logic masterNack_q;
    logic [7:0] rxByte;
    logic byteDone;
    logic addrMatch;
    logic addrRead;
    logic [7:0] curRead;
    logic inRange;

    assign rxByte = {shift_q[6:0], pins.sdaIn};
    assign byteDone = pins.sclRise && bitCnt_q == 4'h7;
    // only our address answers
    // Judged in the ack phase, when the whole address byte sits in the shifter
    assign addrMatch = shift_q[7:1] == clk_synth_pkg::SLAVE_ADDR7;
    assign addrRead = shift_q[0];
    assign inRange = index_q < 7'(NUM_BYTES);
    assign curRead = inRange ? readByte(index_q, latchedSel, regs_q[0],
        regs_q[index_q[$clog2(NUM_BYTES)-1:0]]) : 8'hFF;

    // data byte stored on its eighth clock rise, before its ack
    assign wrEn = state_q == ST_WDATA && byteDone && !countPhase_q && inRange;
    assign wrIdx = index_q;
    assign wrData = rxByte;

    always_ff @(posedge core_clk) begin
        if (!rst_n || pins.stopSeen) begin
            state_q <= ST_IDLE;
            bitCnt_q <= clk_synth_pkg::BIT_CNT_RST;
            ackDrive_q <= 1'b0;
        end else if (pins.startSeen) begin
            state_q <= ST_ADDR;
            bitCnt_q <= clk_synth_pkg::BIT_CNT_RST;
            ackDrive_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    ackDrive_q <= 1'b0;
                end
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (pins.sclRise) begin
                        shift_q <= rxByte;
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end
                    if (byteDone) begin
                        bitCnt_q <= clk_synth_pkg::BIT_CNT_RST;
                        state_q <= state_q == ST_ADDR ? ST_ADDR_ACK :
                            state_q == ST_CMD ? ST_CMD_ACK : ST_WACK;
                    end
                end
                ST_ADDR_ACK, ST_CMD_ACK, ST_WACK: begin
                    if (pins.sclFall && !ackDrive_q) begin
                        if (state_q == ST_ADDR_ACK && !addrMatch) begin
                            state_q <= ST_IDLE;
                        end else begin
                            ackDrive_q <= 1'b1;
                        end
                        if (state_q == ST_ADDR_ACK) begin
                            readMode_q <= addrRead;
                        end
                        if (state_q == ST_CMD_ACK) begin
                            blockMode_q <= ~shift_q[clk_synth_pkg::CMD_TYPE_BIT];
                            index_q <= shift_q[clk_synth_pkg::CMD_TYPE_BIT] ?
                                shift_q[6:0] : 7'h00;
                            countPhase_q <= ~shift_q[clk_synth_pkg::CMD_TYPE_BIT];
                        end
                        if (state_q == ST_WACK) begin
                            if (countPhase_q) begin
                                countPhase_q <= 1'b0;
                            end else begin
                                index_q <= index_q + 7'h01;
                            end
                        end
                    end else if (pins.sclFall && ackDrive_q) begin
                        ackDrive_q <= 1'b0;
                        if (state_q == ST_ADDR_ACK && readMode_q) begin
                            txByte_q <= (blockMode_q && countPhase_q) ?
                                clk_synth_pkg::BLOCK_COUNT : curRead;
                            state_q <= ST_RDATA;
                        end else begin
                            state_q <= state_q == ST_ADDR_ACK ? ST_CMD : ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (pins.sclFall) begin
                        txByte_q <= {txByte_q[6:0], 1'b1};
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (bitCnt_q == 4'h7) begin
                            bitCnt_q <= clk_synth_pkg::BIT_CNT_RST;
                            state_q <= ST_RACK;
                        end
                    end
                end
                ST_RACK: begin
                    if (pins.sclRise) begin
                        masterNack_q <= pins.sdaIn;
                    end
                    if (pins.sclFall) begin
                        if (masterNack_q) begin
                            state_q <= ST_IDLE;
                        end else begin
                            if (countPhase_q) begin
                                countPhase_q <= 1'b0;
                                txByte_q <= curRead;
                            end else begin
                                index_q <= index_q + 7'h01;
                                txByte_q <= readByte(index_q + 7'h01, latchedSel,
                                    regs_q[0], (index_q + 7'h01 < 7'(NUM_BYTES)) ?
                                    regs_q[(index_q[$clog2(NUM_BYTES)-1:0]) + 1'b1] : 8'hFF);
                            end
                            state_q <= ST_RDATA;
                        end
                    end
                end
            endcase
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = ackDrive_q || (state_q == ST_RDATA && !txByte_q[7]);

    a_addr_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(ackDrive_q) && state_q == ST_ADDR_ACK |-> addrMatch) else $error("ack to foreign address");
    a_stop_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        pins.stopSeen |=> state_q == ST_IDLE && !sdaOe) else $error("stop did not idle");
    a_byte0_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
        index_q == 7'h00 && inRange |-> curRead[4:0] == latchedSel) else $error("byte0 select mismatch");
    a_safe_code: assert property (@(posedge core_clk) disable iff (!rst_n)
        !reservedCode(freqCode)) else $error("reserved code presented");
    a_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrEn && wrIdx == 7'h01 |=> regs_q[1] == $past(wrData)) else $error("byte write lost");
    a_block_index: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(blockMode_q) |-> index_q == 7'h00) else $error("block not from byte zero");

    c_byte_write: cover property (@(posedge core_clk) disable iff (!rst_n) wrEn && !blockMode_q);
    c_block_write: cover property (@(posedge core_clk) disable iff (!rst_n) wrEn && blockMode_q);
    c_read: cover property (@(posedge core_clk) disable iff (!rst_n) state_q == ST_RACK);
    c_latched: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(latchDone));

    logic unusedPd;
    assign unusedPd = powerDown;
endmodule // clock_synth_select_and_smbus
`default_nettype wire

// File: verification/smbus_host_model.sv
// Behavioural SMBus controller driving the clock line and the open-drain data line
`default_nettype none
module smbus_host_model (
    input wire logic core_clk,
    input wire logic dutPull,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    logic hostPull;
    // Pull-up on the wire: a released line reads high, never the last value
    assign sda = !(hostPull || dutPull);
    initial begin
        scl = 1'b1;
        hostPull = 1'b0;
    end
    // ----
    // Bus phases: a quarter of the 80 ns link period, changed on falling edges
    // ----
    task automatic quarter();
        repeat (2) @(negedge core_clk);
    endtask
    // Also a repeated start when called from the low clock phase
    task automatic bus_start();
        quarter();
        hostPull = 1'b0;
        quarter();
        scl = 1'b1;
        quarter();
        hostPull = 1'b1;
        quarter();
        scl = 1'b0;
    endtask
    task automatic bus_stop();
        quarter();
        hostPull = 1'b1;
        quarter();
        scl = 1'b1;
        quarter();
        hostPull = 1'b0;
        quarter();
    endtask
    task automatic clock_bit(input logic driveLow, output logic seen);
        quarter();
        hostPull = driveLow;
        quarter();
        scl = 1'b1;
        quarter();
        seen = sda;
        quarter();
        scl = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(!d[i], s);
        end
        clock_bit(1'b0, s);
        ack = !s;
    endtask
    task automatic recv_byte(input logic nackIt, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b0, d[i]);
        end
        clock_bit(!nackIt, s);
    endtask
endmodule // smbus_host_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the select latch and serial control-byte slave
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst_n, cpu_power_good_n, powerDown, scl, sda, sdaOut, sdaOe, freqCodeValid;
    logic [4:0] selPins, freqCode;
    logic [63:0] ctrlBytes;
    logic [7:0] expB [8];
    logic [7:0] rd;
    int err_total = 0;
    int checked = 0;
    localparam logic [7:0] RD_ADDR = {clk_synth_pkg::SLAVE_ADDR7, 1'b1};
    clock_synth_select_and_smbus #(.NUM_BYTES(8)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .cpu_power_good_n(cpu_power_good_n), .freq_select_bit0(selPins[0]),
        .freq_select_bit1(selPins[1]), .freq_select_bit2(selPins[2]),
        .freq_select_bit3(selPins[3]), .freq_select_bit4(selPins[4]), .powerDown(powerDown),
        .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .freqCode(freqCode),
        .freqCodeValid(freqCodeValid), .ctrlBytes(ctrlBytes));
    smbus_host_model host (.core_clk(core_clk), .dutPull(sdaOe && !sdaOut), .scl(scl),
        .sda(sda));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ----
    // Checking and bus helpers
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] b, input logic expAck);
        logic a;
        host.send_byte(b, a);
        check({7'h00, a}, {7'h00, expAck});
    endtask
    task automatic check_bytes();
        for (int i = 0; i < 8; i++) begin
            check(ctrlBytes[8*i+:8], expB[i]);
        end
    endtask
    task automatic byte_write(input logic [6:0] idx, input logic [7:0] d);
        host.bus_start();
        wr(clk_synth_pkg::SLAVE_ADDR_W, 1'b1);
        wr({1'b1, idx}, 1'b1);
        wr(d, 1'b1);
        host.bus_stop();
    endtask
    task automatic byte_read(input logic [6:0] idx, output logic [7:0] d);
        host.bus_start();
        wr(clk_synth_pkg::SLAVE_ADDR_W, 1'b1);
        wr({1'b1, idx}, 1'b1);
        host.bus_start();
        wr(RD_ADDR, 1'b1);
        host.recv_byte(1'b1, d);
        host.bus_stop();
    endtask
    task automatic do_reset();
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic strobe_sel(input logic [4:0] code);
        @(negedge core_clk);
        selPins = code;
        repeat (2) @(negedge core_clk);
        cpu_power_good_n = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_defaults();
        check({3'h0, freqCode}, {3'h0, clk_synth_pkg::FSEL_SAFE});
        check({7'h00, freqCodeValid}, 8'h00);
        check({7'h00, sdaOe}, 8'h00);
        check({7'h00, sdaOut}, 8'h00);
        check({ctrlBytes[7:5], 5'h00}, 8'h40);
        for (int i = 2; i < 8; i++) begin
            check(ctrlBytes[8*i+:8], 8'hFF);
        end
        check(ctrlBytes[15:8], 8'h7F);
        $display("test defaults done");
    endtask
    task automatic t_reserved();
        strobe_sel(5'h0E);
        check({3'h0, freqCode}, 8'h1C);
        check({7'h00, freqCodeValid}, 8'h01);
        cpu_power_good_n = 1'b1;
        do_reset();
        $display("test reserved done");
    endtask
    task automatic t_latch();
        strobe_sel(5'h1E);
        check({3'h0, freqCode}, 8'h1E);
        selPins = 5'h01;
        cpu_power_good_n = 1'b1;
        repeat (8) @(negedge core_clk);
        cpu_power_good_n = 1'b0;
        repeat (8) @(negedge core_clk);
        check({3'h0, freqCode}, 8'h1E);
        expB[0] = 8'h5E;
        check_bytes();
        $display("test latch done");
    endtask
    task automatic t_byte_ops();
        powerDown = 1'b1;
        byte_write(7'h01, 8'h5A);
        byte_write(7'h07, 8'h3C);
        expB[1] = 8'h5A;
        expB[7] = 8'h3C;
        check_bytes();
        byte_read(7'h01, rd);
        check(rd, 8'h5A);
        byte_read(7'h07, rd);
        check(rd, 8'h3C);
        byte_write(7'h00, 8'h00);
        expB[0] = 8'h1E;
        check_bytes();
        byte_read(7'h00, rd);
        check(rd, 8'h1E);
        byte_read(7'h09, rd);
        check(rd, 8'hFF);
        powerDown = 1'b0;
        $display("test byte ops done");
    endtask
    task automatic t_block_write();
        logic [7:0] blk [4] = '{8'hC0, 8'h11, 8'h22, 8'h33};
        host.bus_start();
        wr(clk_synth_pkg::SLAVE_ADDR_W, 1'b1);
        wr(8'h00, 1'b1);
        wr(8'h08, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(blk[i], 1'b1);
        end
        host.bus_stop();
        expB[0] = 8'h5E;
        expB[1] = 8'h11;
        expB[2] = 8'h22;
        expB[3] = 8'h33;
        check_bytes();
        $display("test block write done");
    endtask
    task automatic t_block_read();
        host.bus_start();
        wr(clk_synth_pkg::SLAVE_ADDR_W, 1'b1);
        wr(8'h00, 1'b1);
        host.bus_start();
        wr(RD_ADDR, 1'b1);
        host.recv_byte(1'b0, rd);
        check(rd, clk_synth_pkg::BLOCK_COUNT);
        for (int i = 0; i < 8; i++) begin
            host.recv_byte(i == 7, rd);
            check(rd, expB[i]);
        end
        host.bus_stop();
        $display("test block read done");
    endtask
    task automatic t_foreign();
        host.bus_start();
        wr(8'hD0, 1'b0);
        wr(8'h81, 1'b0);
        host.bus_stop();
        host.bus_start();
        wr(clk_synth_pkg::SLAVE_ADDR_W, 1'b1);
        wr(8'h82, 1'b1);
        host.bus_start();
        host.bus_stop();
        check_bytes();
        byte_read(7'h02, rd);
        check(rd, 8'h22);
        $display("test foreign done");
    endtask
    initial begin
        rst_n = 1'b0;
        cpu_power_good_n = 1'b1;
        selPins = 5'h00;
        powerDown = 1'b0;
        expB = '{8'h00, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        do_reset();
        t_defaults();
        t_reserved();
        t_latch();
        t_byte_ops();
        t_block_write();
        t_block_read();
        t_foreign();
        final_report();
    end
    // Run needs about 4k cycles; the limit leaves wide margin
    initial begin
        #400000;
        err_total++;
        final_report();
    end
endmodule // testbench
`default_nettype wire
